// [hw/pcc_regs.svh]
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PCC_OFS_CHAN_MODE     8'h00
`define PCC_OFS_CHAN_DUTY     8'h04
`define PCC_OFS_DUTY_SHADOW   8'h08
`define PCC_OFS_CHAN_PERIOD   8'h0c
`define PCC_OFS_CMP_VALUE     8'h10
`define PCC_OFS_CMP_VAL_SHAD  8'h14
`define PCC_OFS_CMP_MODE      8'h18
`define PCC_OFS_CMP_MODE_SHAD 8'h1c
`define PCC_OFS_CONTROL       8'h20
`define PCC_OFS_STATUS        8'h24

// ****************************************************************
// field positions
// ****************************************************************
`define PCC_CM_PRESCALE_LSB   0
`define PCC_CM_ALIGN_BIT      8
`define PCC_CM_START_BIT      9
`define PCC_CM_EVSEL_BIT      10
`define PCC_CM_DTE_BIT        16
`define PCC_CM_HIGH_SIDE_DEADTIME_INVERT_BIT       17
`define PCC_CM_LOW_SIDE_DEADTIME_INVERT_BIT       18
`define PCC_CV_DIR_BIT        24
`define PCC_MD_EN_BIT         0
`define PCC_MD_TRIG_LSB       4
`define PCC_MD_PER_LSB        8
`define PCC_MD_PCNT_LSB       12
`define PCC_MD_UPR_LSB        16
`define PCC_MD_UCNT_LSB       20
`define PCC_CTL_EN_BIT        0
`define PCC_ST_EVENT_BIT      0
`define PCC_ST_MATCH_BIT      1

// ****************************************************************
// codes, groups and reset values
// ****************************************************************
`define PCC_PRE_DIV_MAX       4'ha
`define PCC_PRE_DIVIDER_A_CLOCK          4'hb
`define PCC_PRE_DIVIDER_B_CLOCK          4'hc
`define PCC_GRP_MODE          2
`define PCC_GRP_PERIOD        3
`define PCC_RST_WORD          32'h0000_0000
`define PCC_DEAD_CYCLES_DEF   4

`endif

// [hw/pcc_pkg.sv]
package pcc_pkg;

  typedef struct packed {
    logic       lo_inv;
    logic       hi_inv;
    logic       dt_en;
    logic       ev_sel;
    logic       start_lvl;
    logic       center;
    logic [3:0] prescale;
  } pcc_chan_mode_s;

  typedef struct packed {
    logic [3:0] interval;
    logic [3:0] limit;
    logic [3:0] trigger;
    logic       enable;
  } pcc_cmp_mode_s;

  typedef struct packed {
    logic        down;
    logic [15:0] value;
  } pcc_cmp_val_s;

  typedef enum logic [2:0] {
    PCC_DT_IDLE = 3'b001,
    PCC_DT_WAIT = 3'b010,
    PCC_DT_RUN  = 3'b100
  } pcc_dt_state_e;

endpackage

// [hw/pcc_channel.sv]
`timescale 1ns/1ps
`include "pcc_regs.svh"
// Notes on behaviour
// - comparison checked only in the channel 0 period where period count equals trigger.
// - period count runs 0..limit then wraps, one check per limit+1 periods.
// - live period count is readable; writes to it do nothing.
// - new comparison settings apply every interval+1 channel 0 periods.
// - live update count is readable; writes to it do nothing.
// - write-only mode shadow holds enable, trigger, limit and interval.
// - enable 0 means no match ever; 1 allows matches; shadow same coding.
// - channel mode writes ignored while group two soft or hard lock set.
// - prescale codes 0..10 divide clock by 1..1024; 11 and 12 pick divider ticks.
// - alignment 0 gives left-aligned period, 1 gives up-down centre period.
// - start level sets comparator output level at the start of each period.
// - event at every period end; also at half period when centred and selected.
// - dead-time enable turns dead-time generator off or on.
// - high-side inversion bit inverts dead-time high-side output.
// - low-side inversion bit inverts dead-time low-side output.
// - duty and period hold only the low 16 bits.
// - write-only duty shadow gives glitch-free duty changes.
// - period writes ignored while group three soft or hard lock set.
// - left-aligned period lasts period times the tick ratio.
// - centre-aligned period lasts twice period times the tick ratio.
// - compare value matches channel 0 counter; in centre mode only, up or down by direction bit.
// - counter clears on channel enable and at period end when left-aligned.
module pcc_channel
  import pcc_pkg::*;
#(
  parameter int CNT_W       = 16,
  parameter int DEAD_CYCLES = `PCC_DEAD_CYCLES_DEF
)(
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // write-protect status, one bit per register group
  input  wire logic [5:0]  soft_lock_status_in,
  input  wire logic [5:0]  hard_lock_status_in,
  // divider tick enables
  input  wire logic        divider_a_tick_in,
  input  wire logic        divider_b_tick_in,
  // waveform outputs
  output logic             comparator_out,
  output logic             high_side_out,
  output logic             low_side_out,
  output logic             channel_event_out,
  output logic             compare_match_out
);

  // parameter checks at elaboration
  if (CNT_W < 2 || CNT_W > 16)
  begin : g_bad_cnt_w
    $error("pcc_channel: CNT_W must be 2..16");
  end
  if (DEAD_CYCLES < 1 || DEAD_CYCLES > 255)
  begin : g_bad_dead
    $error("pcc_channel: DEAD_CYCLES must be 1..255");
  end

  localparam logic [7:0] DEAD_LOAD = 8'(DEAD_CYCLES);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  function automatic logic locked(input int grp,
                                  input logic [5:0] sw,
                                  input logic [5:0] hw);
    return sw[grp] | hw[grp];
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        wr_fire;
  logic [31:0] rd_next;
  logic        event_sticky_reg;
  logic        match_sticky_reg;

  pcc_chan_mode_s   mode_reg;
  logic [CNT_W-1:0] duty_reg;
  logic [CNT_W-1:0] duty_shad_reg;
  logic             duty_pend_reg;
  logic [CNT_W-1:0] period_reg;
  pcc_cmp_val_s     cval_reg;
  pcc_cmp_val_s     cval_shad_reg;
  logic             cval_pend_reg;
  pcc_cmp_mode_s    cmode_reg;
  pcc_cmp_mode_s    cmode_shad_reg;
  logic             cmode_pend_reg;
  logic [3:0]       pcnt_reg;
  logic [3:0]       ucnt_reg;
  logic             enable_reg;

  // write acts at the edge where the master sees ack
  assign wr_fire = wb_cyc_in & wb_stb_in & wb_we_in & ack_reg;

  always_comb
  begin
    rd_next = `PCC_RST_WORD;
    unique case (wb_adr_in)
      `PCC_OFS_CHAN_MODE:
        rd_next[18:0] = {mode_reg.lo_inv, mode_reg.hi_inv, mode_reg.dt_en, 5'h00,
                         mode_reg.ev_sel, mode_reg.start_lvl, mode_reg.center,
                         4'h0, mode_reg.prescale};
      `PCC_OFS_CHAN_DUTY:   rd_next[CNT_W-1:0] = duty_reg;
      `PCC_OFS_CHAN_PERIOD: rd_next[CNT_W-1:0] = period_reg;
      `PCC_OFS_CMP_VALUE:
      begin
        rd_next[15:0]             = cval_reg.value;
        rd_next[`PCC_CV_DIR_BIT]  = cval_reg.down;
      end
      `PCC_OFS_CMP_MODE:
      begin
        rd_next[`PCC_MD_EN_BIT]             = cmode_reg.enable;
        rd_next[`PCC_MD_TRIG_LSB +: 4]      = cmode_reg.trigger;
        rd_next[`PCC_MD_PER_LSB +: 4]       = cmode_reg.limit;
        rd_next[`PCC_MD_PCNT_LSB +: 4]      = pcnt_reg;
        rd_next[`PCC_MD_UPR_LSB +: 4]       = cmode_reg.interval;
        rd_next[`PCC_MD_UCNT_LSB +: 4]      = ucnt_reg;
      end
      `PCC_OFS_CONTROL:     rd_next[`PCC_CTL_EN_BIT] = enable_reg;
      `PCC_OFS_STATUS:
      begin
        rd_next[`PCC_ST_EVENT_BIT] = event_sticky_reg;
        rd_next[`PCC_ST_MATCH_BIT] = match_sticky_reg;
      end
      // shadows are write-only and unmapped words read zero
      default: rd_next = `PCC_RST_WORD;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      ack_reg  <= 1'b0;
      rdat_reg <= `PCC_RST_WORD;
    end
    else
    begin
      ack_reg  <= wb_cyc_in & wb_stb_in & ~ack_reg;
      rdat_reg <= rd_next;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;

  // ****************************************************************
  // channel configuration registers
  // ****************************************************************
  logic [31:0] wv;
  logic        period_start;
  assign wv = merge(`PCC_RST_WORD, wb_dat_in, wb_sel_in);

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      mode_reg <= '0;
    else if (wr_fire && wb_adr_in == `PCC_OFS_CHAN_MODE &&
             !locked(`PCC_GRP_MODE, soft_lock_status_in, hard_lock_status_in))
    begin
      if (wb_sel_in[0])
        mode_reg.prescale <= wv[`PCC_CM_PRESCALE_LSB +: 4];
      if (wb_sel_in[1])
      begin
        mode_reg.center    <= wv[`PCC_CM_ALIGN_BIT];
        mode_reg.start_lvl <= wv[`PCC_CM_START_BIT];
        mode_reg.ev_sel    <= wv[`PCC_CM_EVSEL_BIT];
      end
      if (wb_sel_in[2])
      begin
        mode_reg.dt_en  <= wv[`PCC_CM_DTE_BIT];
        mode_reg.hi_inv <= wv[`PCC_CM_HIGH_SIDE_DEADTIME_INVERT_BIT];
        mode_reg.lo_inv <= wv[`PCC_CM_LOW_SIDE_DEADTIME_INVERT_BIT];
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      period_reg <= '0;
    else if (wr_fire && wb_adr_in == `PCC_OFS_CHAN_PERIOD &&
             !locked(`PCC_GRP_PERIOD, soft_lock_status_in, hard_lock_status_in))
      period_reg <= CNT_W'(merge(32'(period_reg), wb_dat_in, wb_sel_in));
  end

  // duty: direct write, or shadow loaded at the next period start
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      duty_reg      <= '0;
      duty_shad_reg <= '0;
      duty_pend_reg <= 1'b0;
    end
    else
    begin
      if (wr_fire && wb_adr_in == `PCC_OFS_CHAN_DUTY)
        duty_reg <= CNT_W'(merge(32'(duty_reg), wb_dat_in, wb_sel_in));
      else if (period_start && duty_pend_reg)
        duty_reg <= duty_shad_reg;
      if (wr_fire && wb_adr_in == `PCC_OFS_DUTY_SHADOW)
      begin
        duty_shad_reg <= CNT_W'(merge(32'(duty_shad_reg), wb_dat_in, wb_sel_in));
        duty_pend_reg <= 1'b1;  // a new write wins over the clear below
      end
      else if (period_start)
        duty_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      enable_reg <= 1'b0;
    else if (wr_fire && wb_adr_in == `PCC_OFS_CONTROL && wb_sel_in[0])
      enable_reg <= wb_dat_in[`PCC_CTL_EN_BIT];
  end

  // ****************************************************************
  // tick selection
  // ****************************************************************
  logic [9:0] pre_cnt_reg;
  logic       tick;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      pre_cnt_reg <= '0;
    else
      pre_cnt_reg <= pre_cnt_reg + 10'h001;
  end

  // code k ticks when the low k bits of the free counter are all ones
  always_comb
  begin
    tick = 1'b0;
    if (mode_reg.prescale <= `PCC_PRE_DIV_MAX)
      tick = &(pre_cnt_reg | ~((10'h001 << mode_reg.prescale) - 10'h001));
    else if (mode_reg.prescale == `PCC_PRE_DIVIDER_A_CLOCK)
      tick = divider_a_tick_in;
    else if (mode_reg.prescale == `PCC_PRE_DIVIDER_B_CLOCK)
      tick = divider_b_tick_in;
  end

  // ****************************************************************
  // channel counter
  // ****************************************************************
  logic [CNT_W-1:0] cnt_reg;
  logic             down_reg;
  logic             enable_d_reg;
  logic             half_point;
  logic             moved_reg;
  logic             start_up;

  assign start_up = enable_reg & ~enable_d_reg;
  // left: counts 0..period-1, so period ticks; centre: 0..period..0, twice that
  assign period_start = enable_reg & tick &
                        (mode_reg.center ? (down_reg && cnt_reg <= CNT_W'(1))
                                         : (cnt_reg + CNT_W'(1) >= period_reg));
  assign half_point   = enable_reg & tick & mode_reg.center & ~down_reg &
                        (cnt_reg + CNT_W'(1) >= period_reg);

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      cnt_reg      <= '0;
      down_reg     <= 1'b0;
      enable_d_reg <= 1'b0;
      moved_reg    <= 1'b0;
    end
    else
    begin
      enable_d_reg <= enable_reg;
      moved_reg    <= enable_reg & tick;
      if (start_up)
      begin
        cnt_reg  <= '0;
        down_reg <= 1'b0;
      end
      else if (period_start)
      begin
        cnt_reg  <= '0;
        down_reg <= 1'b0;
      end
      else if (half_point)
      begin
        cnt_reg  <= period_reg;
        down_reg <= 1'b1;
      end
      else if (enable_reg && tick)
        cnt_reg <= down_reg ? cnt_reg - CNT_W'(1) : cnt_reg + CNT_W'(1);
    end
  end

  // ****************************************************************
  // waveform and event
  // ****************************************************************
  logic oc_next;
  assign oc_next = (cnt_reg < duty_reg) ? mode_reg.start_lvl : ~mode_reg.start_lvl;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      comparator_out    <= 1'b0;
      channel_event_out <= 1'b0;
    end
    else
    begin
      comparator_out    <= enable_reg ? oc_next : mode_reg.start_lvl;
      channel_event_out <= period_start | (half_point & mode_reg.ev_sel);
    end
  end

  // ****************************************************************
  // dead-time generator
  // ****************************************************************
  pcc_dt_state_e dt_state_reg;
  logic [7:0]    dt_cnt_reg;
  logic          oc_seen_reg;
  logic          oc_edge;
  logic          hi_raw;
  logic          lo_raw;

  // edge seen combinationally so the gap starts in the very cycle the level flips
  assign oc_edge = comparator_out ^ oc_seen_reg;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      dt_state_reg <= PCC_DT_IDLE;
      dt_cnt_reg   <= '0;
      oc_seen_reg  <= 1'b0;
    end
    else
    begin
      oc_seen_reg <= comparator_out;
      unique case (dt_state_reg)
        PCC_DT_IDLE:
          if (mode_reg.dt_en)
            dt_state_reg <= PCC_DT_RUN;
        PCC_DT_RUN:
          if (!mode_reg.dt_en)
            dt_state_reg <= PCC_DT_IDLE;
          else if (oc_edge)
          begin
            dt_state_reg <= PCC_DT_WAIT;
            dt_cnt_reg   <= DEAD_LOAD;
          end
        PCC_DT_WAIT:
          if (!mode_reg.dt_en)
            dt_state_reg <= PCC_DT_IDLE;
          else if (oc_edge)
            dt_cnt_reg <= DEAD_LOAD;
          else if (dt_cnt_reg <= 8'h01)
            dt_state_reg <= PCC_DT_RUN;
          else
            dt_cnt_reg <= dt_cnt_reg - 8'h01;
      endcase
    end
  end

  // both sides held off during the gap so, with both inversion bits clear, the power stage never shoots through
  assign hi_raw = (dt_state_reg == PCC_DT_WAIT || oc_edge) ? 1'b0 : comparator_out;
  assign lo_raw = (dt_state_reg == PCC_DT_WAIT || oc_edge) ? 1'b0 : ~comparator_out;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      high_side_out <= 1'b0;
      low_side_out  <= 1'b0;
    end
    else if (dt_state_reg == PCC_DT_IDLE)
    begin
      high_side_out <= comparator_out;
      low_side_out  <= ~comparator_out;
    end
    else
    begin
      high_side_out <= hi_raw ^ mode_reg.hi_inv;
      low_side_out  <= lo_raw ^ mode_reg.lo_inv;
    end
  end

  // ****************************************************************
  // comparison unit
  // ****************************************************************
  logic upd_due;
  logic match;
  assign upd_due = period_start && ucnt_reg == cmode_reg.interval;

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      cval_reg       <= '0;
      cval_shad_reg  <= '0;
      cval_pend_reg  <= 1'b0;
      cmode_reg      <= '0;
      cmode_shad_reg <= '0;
      cmode_pend_reg <= 1'b0;
    end
    else
    begin
      if (wr_fire && wb_adr_in == `PCC_OFS_CMP_VALUE)
      begin
        cval_reg.value <= 16'(merge(32'(cval_reg.value), wb_dat_in, wb_sel_in));
        if (wb_sel_in[3])
          cval_reg.down <= wb_dat_in[`PCC_CV_DIR_BIT];
      end
      else if (upd_due && cmode_pend_reg && cval_pend_reg)
        cval_reg <= cval_shad_reg;
      if (wr_fire && wb_adr_in == `PCC_OFS_CMP_MODE)
        // count fields are live and ignore writes
        cmode_reg <= {wv[`PCC_MD_UPR_LSB +: 4], wv[`PCC_MD_PER_LSB +: 4],
                      wv[`PCC_MD_TRIG_LSB +: 4], wv[`PCC_MD_EN_BIT]};
      else if (upd_due && cmode_pend_reg)
        cmode_reg <= cmode_shad_reg;
      if (wr_fire && wb_adr_in == `PCC_OFS_CMP_VAL_SHAD)
      begin
        cval_shad_reg <= {wv[`PCC_CV_DIR_BIT], wv[15:0]};
        cval_pend_reg <= 1'b1;
      end
      else if (upd_due && cmode_pend_reg)
        cval_pend_reg <= 1'b0;
      if (wr_fire && wb_adr_in == `PCC_OFS_CMP_MODE_SHAD)
      begin
        cmode_shad_reg <= {wv[`PCC_MD_UPR_LSB +: 4], wv[`PCC_MD_PER_LSB +: 4],
                           wv[`PCC_MD_TRIG_LSB +: 4], wv[`PCC_MD_EN_BIT]};
        cmode_pend_reg <= 1'b1;
      end
      else if (upd_due)
        cmode_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      pcnt_reg <= '0;
      ucnt_reg <= '0;
    end
    else if (period_start)
    begin
      pcnt_reg <= (pcnt_reg >= cmode_reg.limit) ? 4'h0 : pcnt_reg + 4'h1;
      ucnt_reg <= upd_due ? 4'h0 : ucnt_reg + 4'h1;
    end
  end

  // evaluated once per counter step, after the step lands
  assign match = moved_reg & cmode_reg.enable &
                 (pcnt_reg == cmode_reg.trigger) &
                 (32'(cnt_reg) == 32'(cval_reg.value)) &
                 (!mode_reg.center || (down_reg == cval_reg.down));

  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
      compare_match_out <= 1'b0;
    else
      compare_match_out <= match;
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge mclk_in)
  begin
    if (reset_in)
    begin
      event_sticky_reg <= 1'b0;
      match_sticky_reg <= 1'b0;
    end
    else
    begin
      if (channel_event_out)
        event_sticky_reg <= 1'b1;
      else if (wr_fire && wb_adr_in == `PCC_OFS_STATUS && wb_sel_in[0] &&
               wb_dat_in[`PCC_ST_EVENT_BIT])
        event_sticky_reg <= 1'b0;
      if (compare_match_out)
        match_sticky_reg <= 1'b1;
      else if (wr_fire && wb_adr_in == `PCC_OFS_STATUS && wb_sel_in[0] &&
               wb_dat_in[`PCC_ST_MATCH_BIT])
        match_sticky_reg <= 1'b0;
    end
  end

endmodule

// [tb/pcc_channel_properties.sv]
`timescale 1ns/1ps
module pcc_chk (
  // clock and reset
  input wire logic        mclk_in,
  input wire logic        reset_in,
  // bus
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  // waveform
  input wire logic        comparator_out,
  input wire logic        high_side_out,
  input wire logic        low_side_out,
  input wire logic        channel_event_out,
  input wire logic        compare_match_out
);
  // ****************************************
  // bus and waveform properties
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic rd_take;
  assign rd_take = wb_cyc_in && wb_stb_in && !wb_we_in && !wb_ack_out;

  property p_ack_lat; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_one; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_src; wb_ack_out |-> $past(wb_cyc_in && wb_stb_in); endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_mode_sh; rd_take && wb_adr_in == 8'h1c |=> wb_dat_out == 32'h0; endproperty
  a_mode_sh: assert property (p_mode_sh) else $error("mode shadow readable");
  property p_duty_sh; rd_take && wb_adr_in == 8'h08 |=> wb_dat_out == 32'h0; endproperty
  a_duty_sh: assert property (p_duty_sh) else $error("duty shadow readable");
  property p_val_sh; rd_take && wb_adr_in == 8'h14 |=> wb_dat_out == 32'h0; endproperty
  a_val_sh: assert property (p_val_sh) else $error("value shadow readable");
  property p_rst;
    $fell(reset_in) |-> !comparator_out && !high_side_out && !low_side_out
      && !channel_event_out && !compare_match_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_match; compare_match_out |=> !compare_match_out; endproperty
  a_match: assert property (p_match) else $error("match repeated");
endmodule

bind pcc_channel pcc_chk chk_u (
  .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .comparator_out(comparator_out), .high_side_out(high_side_out),
  .low_side_out(low_side_out), .channel_event_out(channel_event_out),
  .compare_match_out(compare_match_out));

// [tb/pcc_stage_model.sv]
`timescale 1ns/1ps
module pcc_stage_model (
  // clock
  input wire logic mclk_in,
  // gate drives
  input wire logic high_side_in,
  input wire logic low_side_in,
  // shoot-through cycles seen
  output int       overlap_out
);
  // both switches of one leg on together would short the supply rail
  initial overlap_out = 0;
  always @(posedge mclk_in)
    if (high_side_in && low_side_in)
      overlap_out <= overlap_out + 1;
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic        mclk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0, ta = 0, tb = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, q;
  logic        ack, oc, hs, ls, ev, cm;
  logic [5:0]  sl = 6'h00, hl = 6'h00;
  logic [3:0]  tc = 4'h0, sel = 4'hf;
  int          error_cnt = 0, tests_run = 0, mc = 0, seed = 33, ovl, o0;
  int          per, hi, p, d, pre, r, gp;
  int          pres[6] = '{0, 1, 11, 12, 2, 3};

  always #2.5 mclk_in = ~mclk_in;

  pcc_channel #(.DEAD_CYCLES(1)) dut_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .soft_lock_status_in(sl), .hard_lock_status_in(hl),
    .divider_a_tick_in(ta), .divider_b_tick_in(tb), .comparator_out(oc),
    .high_side_out(hs), .low_side_out(ls), .channel_event_out(ev), .compare_match_out(cm));
  pcc_stage_model stage_u (.mclk_in(mclk_in), .high_side_in(hs), .low_side_in(ls),
    .overlap_out(ovl));

  // ****************************************
  // divider ticks: ratio 3 and ratio 5
  // ****************************************
  always @(posedge mclk_in)
  begin
    tc <= (tc == 4'he) ? 4'h0 : tc + 4'h1;
    ta <= (tc % 3) == 2;
    tb <= (tc % 5) == 4;
  end

  // ****************************************
  // helpers
  // ****************************************
  function int eper(int pv, int ps, int c);
    return (c + 1) * pv * ((ps == 11) ? 3 : (ps == 12) ? 5 : (1 << ps));
  endfunction

  task chk(input logic [31:0] s, input logic [31:0] e);
  begin
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  end
  endtask

  task wb(input logic [7:0] a, input logic [31:0] wd, input logic w);
    int n;
  begin
    @(posedge mclk_in);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= wd;
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    if (n >= 50)
      error_cnt++;
  end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
  begin
    wb(a, 32'h0, 0);
    chk(q, e);
  end
  endtask

  task wev;
    int n;
  begin
    n = 0;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (ev !== 1'b1 && n < 5000);
    if (n >= 5000)
      error_cnt++;
  end
  endtask

  // one period, or half one when centred with ev_sel set, from an event edge to the next
  task meas;
  begin
    per = 0;
    hi = 0;
    do
    begin
      @(posedge mclk_in);
      per++;
      hi += oc;
      mc += cm;
      gp += (hs == ls);
    end
    while (ev !== 1'b1 && per < 5000);
  end
  endtask

  task stop_test;
  begin
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    #300000;
    error_cnt++;
    stop_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(posedge mclk_in);
    reset_in <= 0;
    rd(8'h00, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h28, 32'h0);
    wb(8'h0c, 32'habcd_0009, 1);
    rd(8'h0c, 32'h0000_0009);
    sel <= 4'h1;
    wb(8'h0c, 32'h0000_1234, 1);
    sel <= 4'hf;
    rd(8'h0c, 32'h0000_0034);
    wb(8'h18, 32'hffff_ffff, 1);
    rd(8'h18, 32'h000f_0ff1);
    wb(8'h18, 32'h0, 1);
    sl <= 6'h04;
    wb(8'h00, 32'h1, 1);
    rd(8'h00, 32'h0);
    sl <= 6'h00;
    hl <= 6'h08;
    wb(8'h0c, 32'h5, 1);
    rd(8'h0c, 32'h34);
    hl <= 6'h00;
    wb(8'h00, 32'hffff_fffa, 1);
    rd(8'h00, 32'h0007_070a);
    for (int i = 0; i < 6; i++)
    begin
      p = 3 + {$random(seed)} % 6;
      d = 1 + {$random(seed)} % (p - 1);
      pre = pres[i];
      r = eper(1, pre, 0);
      wb(8'h20, 32'h0, 1);
      wb(8'h0c, p, 1);
      wb(8'h04, d, 1);
      wb(8'h08, d, 1);
      wb(8'h00, pre | (i % 2) << 8 | (i / 2 % 2) << 9, 1);
      wb(8'h20, 32'h1, 1);
      wev;
      meas;
      meas;
      chk(per, eper(p, pre, i % 2));
      if (i % 2 == 0)
        chk(hi, (i / 2 % 2) ? d * r : (p - d) * r);
    end
    wb(8'h00, 32'h0000_0500, 1);
    wev;
    meas;
    gp = 0;
    meas;
    chk(per, p);
    chk(gp, 0);
    wb(8'h00, 32'h0001_0000, 1);
    wev;
    meas;
    o0 = ovl;
    gp = 0;
    meas;
    meas;
    chk(ovl, o0);
    chk(gp > 0, 1);
    wb(8'h00, 32'h0007_0000, 1);
    wev;
    meas;
    meas;
    chk(ovl > o0, 1);
    wb(8'h00, 32'h0, 1);
    wb(8'h0c, 32'h4, 1);
    wb(8'h04, 32'h2, 1);
    wb(8'h10, 32'h1, 1);
    wev;
    mc = 0;
    repeat (8) meas;
    chk(mc, 0);
    wb(8'h1c, 32'h0000_0101, 1);
    wev;
    repeat (3) meas;
    wb(8'h18, 32'h0, 0);
    chk(q & 32'h000f_0fff, 32'h0000_0101);
    wev;
    mc = 0;
    repeat (8) meas;
    chk(mc, 4);
    wb(8'h14, 32'h2, 1);
    rd(8'h14, 32'h0);
    wb(8'h1c, 32'h0000_0131, 1);
    wev;
    repeat (3) meas;
    rd(8'h10, 32'h2);
    rd(8'h1c, 32'h0);
    mc = 0;
    repeat (8) meas;
    chk(mc, 0);
    wb(8'h08, 32'h3, 1);
    rd(8'h08, 32'h0);
    wev;
    meas;
    rd(8'h04, 32'h3);
    rd(8'h24, 32'h3);
    stop_test;
  end
endmodule
